// >>> bench/flash_link_properties.sv
// Purpose: assertions on the link between core end and flash controller
// Assumes: bench runs the controller with shortened counts
// Notes:   sees interface signals only
`timescale 1ns/1ns
module flash_link_properties
#(
  parameter int WRITE_CYCLES = 5,
  parameter int ERASE_CYCLES = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic code_req,
  input wire logic debug_req,
  input wire logic redirect,
  input wire logic erase_en,
  input wire logic prog_en,
  input wire logic irq_in,
  input wire logic rvalid,
  input wire logic stall,
  input wire logic irq_pending,
  input wire logic irq_release
);
  int cnt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // stall length counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 0;
    else
      cnt_q <= stall ? cnt_q + 1 : 0;
  end
  property p_len;
    $fell(stall) |-> cnt_q == WRITE_CYCLES || cnt_q == ERASE_CYCLES;
  endproperty
  a_len: assert property (p_len) else $error("stall length wrong");
  property p_go;
    wr_req && redirect && prog_en && !stall |-> ##[1:2] stall;
  endproperty
  a_go: assert property (p_go) else $error("write did not stall");
  property p_noen;
    wr_req && !prog_en && !debug_req && !stall |=> !stall [*3];
  endproperty
  a_noen: assert property (p_noen) else $error("disabled op ran");
  property p_cause;
    $rose(stall) |-> $past(wr_req) || $past(debug_req);
  endproperty
  a_cause: assert property (p_cause) else $error("stall without op");
  property p_rd;
    (rd_req || code_req) && !stall |=> rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rdram;
    rd_req && !wr_req && !debug_req && !stall |=> !stall;
  endproperty
  a_rdram: assert property (p_rdram) else $error("read hit flash");
  property p_hold;
    irq_in && stall |=> irq_pending;
  endproperty
  a_hold: assert property (p_hold) else $error("irq not held");
  property p_quiet;
    stall |-> !irq_release;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq during op");
  property p_rel;
    $fell(stall) && $past(irq_pending) |-> irq_release;
  endproperty
  a_rel: assert property (p_rel) else $error("irq not released");
  c_erase: cover property ($rose(stall) && erase_en);
  c_write: cover property ($rose(stall) && !erase_en);
  c_irq: cover property (irq_release);
endmodule

// >>> bench/flash_program_erase_control_bench.sv
// Purpose: APB-driven bench for core end and flash controller
// Assumes: controller counts shortened to 5 and 20 cycles
// Notes:   flash starts unknown, pages are erased before use
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
`define CHK(nm, ex, got) \
  begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module flash_program_erase_control_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        serr;
  int          n_errors = 0;
  int          cmp_count = 0;
  always #4 pclk = ~pclk;
  flash_bus_if bus_if ();
  flash_ctl #(.ERASE_CYCLES(20), .WRITE_CYCLES(5)) flash_ctl_inst
    (.pclk(pclk), .presetn(presetn), .bus(bus_if.flash));
  flash_core_end flash_core_end_inst
    (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
     .pready(pready), .pslverr(pslverr), .bus(bus_if.core));
  flash_link_properties #(.WRITE_CYCLES(5), .ERASE_CYCLES(20))
    flash_link_properties_inst
    (.pclk(pclk), .presetn(presetn), .wr_req(bus_if.wr_req),
     .rd_req(bus_if.rd_req), .code_req(bus_if.code_req),
     .debug_req(bus_if.debug_req), .redirect(bus_if.redirect),
     .erase_en(bus_if.erase_en), .prog_en(bus_if.prog_en),
     .irq_in(bus_if.irq_in), .rvalid(bus_if.rvalid), .stall(bus_if.stall),
     .irq_pending(bus_if.irq_pending), .irq_release(bus_if.irq_release));
  // ==========================================
  // bus tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      n_errors++;
      complete_run();
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(input logic [3:0] c, input logic [15:0] a,
                    input logic [7:0] d, input logic [4:0] g);
    int k;
    apb(1'b1, `REG_CTRL, {28'h0, c & 4'h8});
    apb(1'b1, `REG_CTRL, {28'h0, c & 4'hE});
    apb(1'b1, `REG_CTRL, {28'h0, c});
    apb(1'b1, `REG_ADDR, {16'h0, a});
    apb(1'b1, `REG_DATA, {24'h0, d});
    apb(1'b1, `REG_GO, {27'h0, g});
    repeat (4) @(posedge pclk);
    for (k = 0; k < 300; k++)
    begin
      apb(1'b0, `REG_STATUS, 32'h0);
      if (rdat[`STAT_BUSY_BIT] === 1'b0)
        break;
    end
    if (k == 300)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [3:0] c, input logic [15:0] a,
                    input logic [4:0] g, input logic [7:0] ex);
    op(c, a, 8'h00, g);
    apb(1'b0, `REG_DATA, 32'h0);
    `CHK("read byte", ex, rdat[7:0])
  endtask
  // ==========================================
  // tests
  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    op(4'hB, 16'h0305, 8'h12, 5'h01);
    rd(4'h0, 16'h0200, 5'h04, 8'hFF);
    rd(4'h0, 16'h03FF, 5'h04, 8'hFF);
    $display("erase test done");
    op(4'h9, 16'h0210, 8'hA5, 5'h01);
    op(4'h9, 16'h0210, 8'h3C, 5'h01);
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK("redirect", 1'b1, rdat[`CTRL_REDIRECT_BIT])
    `CHK("mapped error", 1'b0, serr)
    rd(4'h0, 16'h0210, 5'h04, 8'h24);
    $display("program test done");
    op(4'h1, 16'h0211, 8'h00, 5'h01);
    rd(4'h0, 16'h0211, 5'h04, 8'hFF);
    op(4'h0, 16'h0211, 8'h5A, 5'h01);
    rd(4'h9, 16'h0211, 5'h02, 8'h5A);
    rd(4'h0, 16'h0211, 5'h04, 8'hFF);
    $display("steering test done");
    op(4'h0, 16'h0212, 8'h81, 5'h08);
    rd(4'h0, 16'h0212, 5'h04, 8'h81);
    op(4'h0, 16'h0213, 8'h00, 5'h18);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("busy", 1'b0, rdat[`STAT_BUSY_BIT])
    `CHK("irq done", 1'b1, rdat[`STAT_DONE_BIT])
    `CHK("irq pend", 1'b0, rdat[`STAT_PEND_BIT])
    rd(4'h0, 16'h0213, 5'h04, 8'h00);
    $display("debug and interrupt test done");
    op(4'hB, 16'h0000, 8'h00, 5'h01);
    op(4'hF, 16'h0005, 8'h00, 5'h01);
    op(4'hD, 16'h0005, 8'h42, 5'h01);
    rd(4'h4, 16'h0005, 5'h04, 8'h42);
    rd(4'h0, 16'h0005, 5'h04, 8'hFF);
    $display("scratchpad test done");
    apb(1'b0, 32'h0000_0020, 32'h0);
    `CHK("unmapped error", 1'b1, serr)
    `CHK("unmapped data", 32'h0, rdat)
    $display("unmapped test done");
    complete_run();
  end
endmodule

// >>> hw/flash_bus_if.sv
// Purpose: data-space link between processor end and flash controller
// Assumes: single clock pclk
// Notes:   one request per cycle, stall holds the core
`timescale 1ns/1ns
interface flash_bus_if;
  logic        wr_req;
  logic        rd_req;
  logic        code_req;
  logic        debug_req;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        redirect;
  logic        erase_en;
  logic        prog_en;
  logic        scratch_sel;
  logic        irq_in;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        stall;
  logic        irq_pending;
  logic        irq_release;
  modport core
  (
    output wr_req, rd_req, code_req, debug_req, addr, wdata,
    output redirect, erase_en, prog_en, scratch_sel, irq_in,
    input  rdata, rvalid, stall, irq_pending, irq_release
  );
  modport flash
  (
    input  wr_req, rd_req, code_req, debug_req, addr, wdata,
    input  redirect, erase_en, prog_en, scratch_sel, irq_in,
    output rdata, rvalid, stall, irq_pending, irq_release
  );
endinterface

// >>> hw/flash_core_end.sv
// Purpose: processor end: APB slave registers driving flash link requests
// Assumes: APB3, zero wait states
// Notes:   control bits are held until software changes them
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
module flash_core_end
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  flash_bus_if.core        bus
);
  logic [3:0]  ctrl_q;
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  rd_q;
  logic        done_q;
  logic [4:0]  go_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  wire known = paddr == `REG_CTRL || paddr == `REG_STATUS ||
               paddr == `REG_ADDR || paddr == `REG_DATA ||
               paddr == `REG_GO;

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 4'h0;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      go_q   <= 5'h00;
    end
    else
    begin
      if (wr && paddr == `REG_CTRL)
        ctrl_q <= pwdata[3:0];
      if (wr && paddr == `REG_ADDR)
        addr_q <= pwdata[15:0];
      if (wr && paddr == `REG_DATA)
        data_q <= pwdata[7:0];
      if (wr && paddr == `REG_GO)
        go_q <= pwdata[4:0];
      else
      begin
        // requests taken when idle; irq pulse lands inside the op
        if (!bus.stall)
          go_q[3:0] <= 4'h0;
        if (bus.stall || go_q[3:0] == 4'h0)
          go_q[`GO_IRQ_BIT] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read capture and status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_q      <= 8'h00;
      done_q    <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      if (bus.rvalid)
        rd_q <= bus.rdata;
      if (bus.rvalid || bus.irq_release)
        done_q <= 1'b1;
      else if (wr && paddr == `REG_GO)
        done_q <= 1'b0;
      pslverr_q <= psel && !penable && !known;
      case (paddr)
        `REG_CTRL:   prdata_q <= {28'h0, ctrl_q};
        `REG_STATUS: prdata_q <= {29'h0, bus.irq_pending, done_q,
                                  bus.stall};
        `REG_ADDR:   prdata_q <= {16'h0, addr_q};
        `REG_DATA:   prdata_q <= {24'h0, rd_q};
        default:     prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata          = prdata_q;
  assign pready          = 1'b1;
  assign pslverr         = pslverr_q;
  assign bus.wr_req      = go_q[`GO_WRITE_BIT] || go_q[`GO_DEBUG_BIT];
  assign bus.rd_req      = go_q[`GO_READ_BIT];
  assign bus.code_req    = go_q[`GO_CODE_BIT];
  assign bus.debug_req   = go_q[`GO_DEBUG_BIT];
  assign bus.irq_in      = go_q[`GO_IRQ_BIT];
  assign bus.addr        = addr_q;
  assign bus.wdata       = data_q;
  assign bus.redirect    = ctrl_q[`CTRL_REDIRECT_BIT];
  assign bus.erase_en    = ctrl_q[`CTRL_ERASE_BIT];
  assign bus.scratch_sel = ctrl_q[`CTRL_SCRATCH_BIT];
  assign bus.prog_en     = ctrl_q[`CTRL_PROGEN_BIT];
endmodule

// >>> hw/flash_ctl.sv
// Purpose: flash program/erase controller with external data RAM steering
// Assumes: core holds requests while stall is high
// Notes:   timing counts are parameters so a bench may shorten them
//          stall is a flop; requests seen while busy are ignored
// Behaviour
// - byte program by debug port or software
// - programming only clears bits
// - 512-byte pages; erase fills page with FF
// - write and erase are self-timed
// - core stalled for whole operation
// - interrupts held, released after operation
// - redirect steers data writes to flash
// - redirect stays set until software clears
// - data reads always go to RAM
// - all three enables: software write erases page, debug write programs byte
// - erase off, redirect and program enable on: program byte
// - software sets enables in order, clears redirect
// - software masks interrupts while redirect set
// - software avoids reserved flash area
// - erase takes 10 to 14 ms
// - byte write takes 40 to 60 us
// - 64 kB main flash plus 128 bytes
// - blank part first programmed by debug port
// - scratchpad select maps 0x00-0x7F to scratchpad
`timescale 1ns/1ns
`include "flash_ctl_params.svh"
module flash_ctl
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES,
  parameter int WRITE_CYCLES = `WRITE_CYCLES,
  parameter int MAIN_BYTES   = `MAIN_BYTES
)
(
  input wire logic   pclk,
  input wire logic   presetn,
  flash_bus_if.flash bus
);
  // ==========================================================
  // storage
  // flash comes up unknown; erase before use
  logic [7:0] main_q     [MAIN_BYTES];
  logic [7:0] scratch_q  [`SCRATCH_BYTES];
  logic [7:0] data_ram_q [`MAIN_BYTES];
  flash_ctl_pkg::fsm_t state_q;
  logic [31:0]         cnt_q;
  logic [15:0]         op_addr_q;
  logic [7:0]          op_data_q;
  logic                op_scr_q;
  logic [7:0]          rdata_q;
  logic                rvalid_q;
  logic                pend_q;
  logic                rel_q;
  logic                stall_q;

  function automatic logic to_scratch(input logic sel,
                                      input logic [15:0] a);
    to_scratch = sel && (a <= `SCRATCH_TOP);
  endfunction

  wire idle      = (state_q == flash_ctl_pkg::ST_IDLE);
  wire flash_wr  = bus.wr_req && (bus.redirect || bus.debug_req);
  wire wr_ok     = flash_wr && (bus.prog_en || bus.debug_req);
  wire do_erase  = wr_ok && bus.erase_en && !bus.debug_req;
  wire do_prog   = wr_ok && !do_erase;
  wire ram_wr    = bus.wr_req && !flash_wr && idle;
  wire done      = !idle && (cnt_q == 32'h0000_0001);

  // ==========================================================
  // sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= flash_ctl_pkg::ST_IDLE;
      cnt_q     <= 32'h0000_0000;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
      op_scr_q  <= 1'b0;
    end
    else
    begin
      case (state_q)
        flash_ctl_pkg::ST_IDLE:
        begin
          if (do_erase)
          begin
            state_q <= flash_ctl_pkg::ST_ERASE;
            cnt_q   <= ERASE_CYCLES;
          end
          else if (do_prog)
          begin
            state_q <= flash_ctl_pkg::ST_WRITE;
            cnt_q   <= WRITE_CYCLES;
          end
          // latch every idle cycle; frozen while busy
          op_addr_q <= bus.addr;
          op_data_q <= bus.wdata;
          op_scr_q  <= to_scratch(bus.scratch_sel, bus.addr);
        end
        flash_ctl_pkg::ST_WRITE,
        flash_ctl_pkg::ST_ERASE:
        begin
          cnt_q <= cnt_q - 32'h0000_0001;
          if (done)
            state_q <= flash_ctl_pkg::ST_IDLE;
        end
        default:
          state_q <= flash_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // flash array update at end of operation
  // byte program ANDs, so bits only fall
  always_ff @(posedge pclk)
  begin
    if (done && state_q == flash_ctl_pkg::ST_WRITE)
    begin
      if (op_scr_q)
        scratch_q[op_addr_q[`SCRATCH_BITS-1:0]] <=
          scratch_q[op_addr_q[`SCRATCH_BITS-1:0]] & op_data_q;
      else
        main_q[op_addr_q] <= main_q[op_addr_q] & op_data_q;
    end
    else if (done && state_q == flash_ctl_pkg::ST_ERASE)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
      begin
        if (op_scr_q && i < `SCRATCH_BYTES)
          scratch_q[i] <= `ERASED_BYTE;
        else if (!op_scr_q)
          main_q[{op_addr_q[15:`PAGE_BITS], 9'(i)}] <= `ERASED_BYTE;
      end
    end
  end

  // ==========================================================
  // external data RAM
  always_ff @(posedge pclk)
  begin
    if (ram_wr)
      data_ram_q[bus.addr] <= bus.wdata;
  end

  // ==========================================================
  // read path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 8'h00;
    else if (idle && bus.rd_req)
      rdata_q <= data_ram_q[bus.addr];
    else if (idle && bus.code_req)
      rdata_q <= to_scratch(bus.scratch_sel, bus.addr) ?
                 scratch_q[bus.addr[`SCRATCH_BITS-1:0]] :
                 main_q[bus.addr];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rvalid_q <= 1'b0;
    else
      rvalid_q <= idle && (bus.rd_req || bus.code_req);
  end

  // ==========================================================
  // interrupt hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 1'b0;
    else if (!idle && bus.irq_in)
      pend_q <= 1'b1;
    else if (done)
      pend_q <= 1'b0;
  end

  // ==========================================================
  // release pulse once the operation ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rel_q <= 1'b0;
    else
      rel_q <= done && (pend_q || bus.irq_in);
  end

  // ==========================================================
  // stall flag, same timing as the busy states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stall_q <= 1'b0;
    else if (idle)
      stall_q <= do_erase || do_prog;
    else if (done)
      stall_q <= 1'b0;
  end

  assign bus.stall       = stall_q;
  assign bus.rdata       = rdata_q;
  assign bus.rvalid      = rvalid_q;
  assign bus.irq_pending = pend_q;
  assign bus.irq_release = rel_q;
endmodule

// >>> hw/flash_ctl_params.svh
// Purpose: constants shared by the flash controller and its processor end
// Assumes: 125 MHz clock, byte-wide flash, 16-bit data-space address
// Notes:   times are given in their own unit, counts derived from them
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH
`define CLK_MHZ           125
`define ERASE_TIME_MS     12
`define WRITE_TIME_US     50
`define ERASE_CYCLES      (`ERASE_TIME_MS * 1000 * `CLK_MHZ)
`define WRITE_CYCLES      (`WRITE_TIME_US * `CLK_MHZ)
`define PAGE_BYTES        512
`define PAGE_BITS         9
`define SCRATCH_BYTES     128
`define SCRATCH_BITS      7
`define SCRATCH_TOP       16'h007F
`define ERASED_BYTE       8'hFF
`define MAIN_BYTES        65536
`define ADDR_BITS         16
`define CTRL_REDIRECT_BIT 0
`define CTRL_ERASE_BIT    1
`define CTRL_SCRATCH_BIT  2
`define CTRL_PROGEN_BIT   3
`define REG_CTRL          32'h0000_0000
`define REG_STATUS        32'h0000_0004
`define REG_ADDR          32'h0000_0008
`define REG_DATA          32'h0000_000C
`define REG_GO            32'h0000_0010
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_PEND_BIT     2
`define GO_WRITE_BIT      0
`define GO_READ_BIT       1
`define GO_CODE_BIT       2
`define GO_DEBUG_BIT      3
`define GO_IRQ_BIT        4
`endif

// >>> hw/flash_ctl_pkg.sv
// Purpose: types for the flash controller
// Assumes: included constants header
// Notes:   states are one-hot
package flash_ctl_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_ERASE = 3'b100
  } fsm_t;
endpackage
